// ===== hdl/adcdc_device.sv
// adcdc_device: one converter of the chain, conversion timing and the
// 18-bit readout shift register; assumes pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module adcdc_device #(
    parameter int unsigned CONV_CYCLES = adcdc_pkg::CONV_CYCLES
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // link
    adcdc_link_if.device link,
    // user side
    input wire logic [17:0] sample_value,
    output logic conv_done,
    output logic busy_mode,
    output logic powered_down,
    output logic [17:0] last_result
);
    logic [2:0] pins;
    logic trig_s, sclk_s, chain_s;
    logic trig_prev_q, sclk_prev_q;
    logic trig_rise, sclk_fall;
    adcdc_pkg::adcdc_state_t state_q;
    logic [15:0] conv_cnt_q;
    logic [17:0] shreg_q;
    logic [17:0] held_q;
    logic sdo_q;
    logic busy_q;
    logic busy_pending_q;
    logic chain_hold_q;

    assign pins = {link.conversion_trigger, link.sclk, link.chain_in};

    adcdc_sync #(.W(3)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .async_in(pins),
        .sync_out({trig_s, sclk_s, chain_s})
    );

    // edge detection on synchronised levels
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trig_prev_q <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else if (clk_en) begin
            trig_prev_q <= trig_s;
            sclk_prev_q <= sclk_s;
        end
    end

    assign trig_rise = trig_s & ~trig_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;

    // conversion and readout sequencing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= adcdc_pkg::ADCDC_IDLE;
            conv_cnt_q <= '0;
            busy_q <= 1'b0;
        end else if (clk_en) begin
            case (state_q)
                adcdc_pkg::ADCDC_IDLE: begin
                    // chain low, or tied to trigger (low before rise)
                    if (trig_rise && !chain_hold_q) begin
                        state_q <= adcdc_pkg::ADCDC_CONV;
                        conv_cnt_q <= 16'(CONV_CYCLES - 1);
                        busy_q <= sclk_s;
                    end
                end
                adcdc_pkg::ADCDC_CONV: begin
                    // sclk ignored while converting
                    if (conv_cnt_q == 16'h0000) begin
                        state_q <= adcdc_pkg::ADCDC_SHIFT;
                    end else begin
                        conv_cnt_q <= conv_cnt_q - 16'h0001;
                    end
                end
                adcdc_pkg::ADCDC_SHIFT: begin
                    if (!trig_s) begin
                        state_q <= adcdc_pkg::ADCDC_IDLE;
                    end
                end
                default: state_q <= adcdc_pkg::ADCDC_IDLE;
            endcase
        end
    end

    // chain input one cycle back; low there selects chain mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chain_hold_q <= 1'b0;
        end else if (clk_en) begin
            chain_hold_q <= chain_s;
        end
    end

    // shift register, busy bit and serial output
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shreg_q <= adcdc_pkg::RESULT_RESET;
            sdo_q <= 1'b0;
            busy_pending_q <= 1'b0;
        end else if (clk_en) begin
            if (state_q == adcdc_pkg::ADCDC_CONV
                    && conv_cnt_q == 16'h0000) begin
                if (busy_q) begin
                    shreg_q <= sample_value;
                    sdo_q <= 1'b1;
                    busy_pending_q <= 1'b1;
                end else begin
                    // sdo mirrors the register's top bit from here on
                    shreg_q <= sample_value;
                    sdo_q <= sample_value[17];
                    busy_pending_q <= 1'b0;
                end
            end else if (state_q == adcdc_pkg::ADCDC_SHIFT && sclk_fall) begin
                if (busy_pending_q) begin
                    // first fall drops the busy bit; chain data not taken
                    busy_pending_q <= 1'b0;
                    sdo_q <= shreg_q[17];
                end else begin
                    // 18 stages: the next bit out is the one below the top
                    sdo_q <= shreg_q[16];
                    shreg_q <= {shreg_q[16:0], chain_s};
                end
            end else if (state_q == adcdc_pkg::ADCDC_IDLE
                    && !trig_s && !chain_s) begin
                sdo_q <= 1'b0;
            end
        end
    end

    // result capture and status
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            held_q <= adcdc_pkg::RESULT_RESET;
            conv_done <= 1'b0;
        end else if (clk_en) begin
            conv_done <= 1'b0;
            if (state_q == adcdc_pkg::ADCDC_CONV
                    && conv_cnt_q == 16'h0000) begin
                held_q <= sample_value;
                conv_done <= 1'b1;
            end
        end
    end

    assign link.sdo = sdo_q;
    assign busy_mode = busy_q;
    assign powered_down = (state_q != adcdc_pkg::ADCDC_CONV);
    assign last_result = held_q;
endmodule
`default_nettype wire

// ===== hdl/adcdc_host.sv
// adcdc_host: drives the shared trigger and sclk lines and collects the
// chain's results; assumes sdo is the last device's output.
`timescale 1ns/1ps
`default_nettype none
module adcdc_host (
    // clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // link
    adcdc_link_if.host link,
    // user side
    input wire logic start,
    input wire logic busy_mode,
    output logic irq_seen,
    output logic [35:0] results,
    output logic done
);
    logic sdo_s;
    adcdc_pkg::adcdc_state_t state_q;
    logic [15:0] div_q;
    logic [15:0] wait_q;
    logic [7:0] falls_q;
    logic sclk_q;
    logic trig_q;
    logic [35:0] data_q;
    logic [7:0] busy_first;

    // fall count of a busy frame, whose first sample is the busy bit
    assign busy_first = 8'(adcdc_pkg::RESULT_BITS * adcdc_pkg::CHAIN_LEN
        + 1);

    adcdc_sync #(.W(1)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .async_in(link.sdo),
        .sync_out(sdo_s)
    );

    // trigger, divided sclk and fall counting
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= adcdc_pkg::ADCDC_IDLE;
            trig_q <= 1'b0;
            sclk_q <= 1'b0;
            div_q <= '0;
            wait_q <= '0;
            falls_q <= '0;
            data_q <= '0;
            done <= 1'b0;
            irq_seen <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            case (state_q)
                adcdc_pkg::ADCDC_IDLE: begin
                    trig_q <= 1'b0;
                    sclk_q <= busy_mode;
                    if (start) begin
                        trig_q <= 1'b1;
                        state_q <= adcdc_pkg::ADCDC_CONV;
                        wait_q <= 16'(adcdc_pkg::CONV_CYCLES + 8);
                        falls_q <= 8'(adcdc_pkg::RESULT_BITS
                            * adcdc_pkg::CHAIN_LEN
                            + (busy_mode ? 1 : 0));
                        irq_seen <= 1'b0;
                    end
                end
                adcdc_pkg::ADCDC_CONV: begin
                    if (sdo_s) begin
                        irq_seen <= busy_mode;
                    end
                    if (wait_q == 16'h0000) begin
                        state_q <= adcdc_pkg::ADCDC_SHIFT;
                        sclk_q <= 1'b1;
                        div_q <= 16'(adcdc_pkg::SCLK_HALF_CYCLES - 1);
                    end else begin
                        wait_q <= wait_q - 16'h0001;
                    end
                end
                adcdc_pkg::ADCDC_SHIFT: begin
                    if (div_q != 16'h0000) begin
                        div_q <= div_q - 16'h0001;
                    end else if (falls_q == 8'h00) begin
                        trig_q <= 1'b0;
                        state_q <= adcdc_pkg::ADCDC_IDLE;
                        done <= 1'b1;
                    end else begin
                        div_q <= 16'(adcdc_pkg::SCLK_HALF_CYCLES - 1);
                        sclk_q <= ~sclk_q;
                        if (sclk_q) begin
                            // sample before the fall, msb first
                            falls_q <= falls_q - 8'h01;
                            if (!(busy_mode && falls_q == busy_first)) begin
                                data_q <= {data_q[34:0], sdo_s};
                            end
                        end
                    end
                end
                default: state_q <= adcdc_pkg::ADCDC_IDLE;
            endcase
        end
    end

    assign link.conversion_trigger = trig_q;
    assign link.sclk = sclk_q;
    assign results = data_q;
endmodule
`default_nettype wire

// ===== hdl/adcdc_link_if.sv
// adcdc_link_if: the shared trigger and sclk lines, and one device's
// chain input and serial output, seen from both ends.
`timescale 1ns/1ps
`default_nettype none
interface adcdc_link_if;
    logic conversion_trigger;
    logic sclk;
    logic chain_in;
    logic sdo;
    modport device (
        input conversion_trigger,
        input sclk,
        input chain_in,
        output sdo
    );
    modport host (
        output conversion_trigger,
        output sclk,
        input sdo
    );
endinterface
`default_nettype wire

// ===== hdl/adcdc_pkg.sv
// adcdc_pkg: constants and types shared by both ends of the converter
// chain readout link; assumes a 250 MHz system clock on both ends.
package adcdc_pkg;
    localparam int unsigned RESULT_BITS = 18;
    localparam int unsigned CLK_PERIOD_PS = 4000;
    // conversion time in ns, and its cycle count at the system clock
    localparam int unsigned CONV_TIME_NS = 500;
    localparam int unsigned CONV_CYCLES =
        (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // host sclk half period in system clock cycles
    localparam int unsigned SCLK_HALF_CYCLES = 6;
    localparam int unsigned CHAIN_LEN = 2;
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [17:0] RESULT_RESET = 18'h0_0000;
    typedef enum logic [1:0] {
        ADCDC_IDLE,
        ADCDC_CONV,
        ADCDC_SHIFT
    } adcdc_state_t;
endpackage

// ===== hdl/adcdc_sync.sv
// adcdc_sync: two-flop synchroniser for a vector of pin levels.
// assumes inputs come from outside the clk domain.
`timescale 1ns/1ps
`default_nettype none
module adcdc_sync #(
    parameter int unsigned W = 1
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== tb/adc_daisy_chain_readout_tb.sv
// adc_daisy_chain_readout_tb: host reading a chain of two devices
// assumes the host sits on the second device's link
`timescale 1ns/1ps
`default_nettype none
module adc_daisy_chain_readout_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic busy_sel = 1'b0;
    logic [17:0] s1 = 18'h0_0000;
    logic [17:0] s2 = 18'h0_0000;
    logic irq_seen, done, b1, b2, pd1, pd2, cd1, cd2;
    logic [35:0] results;
    logic [17:0] r1, r2;
    int n_errors = 0;
    int samples_checked = 0;
    adcdc_link_if link_a ();
    adcdc_link_if link_b ();
    // clock
    always #2 clk = ~clk;
    // shared lines fan out; first chain input per mode
    assign link_a.conversion_trigger = link_b.conversion_trigger;
    assign link_a.sclk = link_b.sclk;
    assign link_a.chain_in = busy_sel & link_b.conversion_trigger;
    assign link_b.chain_in = link_a.sdo;
    adcdc_device i_adcdc_device_1 (.clk(clk), .sys_rst(sys_rst),
        .clk_en(1'b1), .link(link_a), .sample_value(s1), .conv_done(cd1),
        .busy_mode(b1), .powered_down(pd1), .last_result(r1));
    adcdc_device i_adcdc_device_2 (.clk(clk), .sys_rst(sys_rst),
        .clk_en(1'b1), .link(link_b), .sample_value(s2), .conv_done(cd2),
        .busy_mode(b2), .powered_down(pd2), .last_result(r2));
    adcdc_host i_adcdc_host (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .link(link_b), .start(start), .busy_mode(busy_sel),
        .irq_seen(irq_seen), .results(results), .done(done));
    adcdc_chk i_adcdc_chk (.clk(clk), .sys_rst(sys_rst),
        .conversion_trigger(link_b.conversion_trigger), .sclk(link_b.sclk),
        .chain_in(link_b.chain_in), .sdo(link_b.sdo));
    // compare and count
    task automatic check(input string what, input logic [35:0] exp,
            input logic [35:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // one full conversion and readout of both devices
    task automatic run_frame(input logic busy, input logic [17:0] v1,
            input logic [17:0] v2);
        int i;
        logic pd_seen;
        logic conv_seen;
        logic cd_seen;
        pd_seen = 1'b0;
        conv_seen = 1'b0;
        cd_seen = 1'b0;
        @(negedge clk);
        busy_sel = busy;
        s1 = v1;
        s2 = v2;
        repeat (10) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        for (i = 0; i < 2000 && done !== 1'b1; i++) begin
            @(negedge clk);
            // both awake while converting, both down again afterwards
            if (pd1 === 1'b0 && pd2 === 1'b0) begin
                conv_seen = 1'b1;
            end else if (conv_seen && pd1 === 1'b1 && pd2 === 1'b1) begin
                pd_seen = 1'b1;
            end
            if (cd1 === 1'b1 && cd2 === 1'b1) begin
                cd_seen = 1'b1;
            end
        end
        check("conv_done", 36'h0_0000_0001, 36'(cd_seen));
        check("done", 36'h0_0000_0001, 36'(done));
        check("results", {v2, v1}, results);
        check("irq_seen", 36'(busy), 36'(irq_seen));
        check("busy_mode_1", 36'(busy), 36'(b1));
        check("busy_mode_2", 36'(busy), 36'(b2));
        check("last_result_1", 36'(v1), 36'(r1));
        check("last_result_2", 36'(v2), 36'(r2));
        check("powered_down", 36'h0_0000_0001, 36'(pd_seen));
    endtask
    // reset in mid conversion returns the link to idle
    task automatic reset_mid_frame();
        repeat (10) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (60) @(negedge clk);
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        check("sdo", 36'h0_0000_0000, 36'(link_b.sdo));
        check("trigger", 36'h0_0000_0000, 36'(link_b.conversion_trigger));
        check("done", 36'h0_0000_0000, 36'(done));
    endtask
    // main sequence
    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        run_frame(1'b0, 18'h2_5a5a, 18'h1_a5a5);
        run_frame(1'b0, 18'h3_ffff, 18'h0_0000);
        run_frame(1'b1, 18'h0_0001, 18'h2_0000);
        run_frame(1'b1, 18'h3_ffff, 18'h0_0000);
        reset_mid_frame();
        run_frame(1'b0, 18'h0_0001, 18'h3_fffe);
        give_verdict();
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire

// ===== tb/adcdc_chk.sv
// adcdc_chk: assertions on the host lines and the last device's output
// assumes one clock domain shared by host and devices
`timescale 1ns/1ps
`default_nettype none
module adcdc_chk #(
    parameter int unsigned CONV_CYCLES = adcdc_pkg::CONV_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link lines
    input wire logic conversion_trigger,
    input wire logic sclk,
    input wire logic chain_in,
    input wire logic sdo
);
    logic [7:0] falls_q;
    logic [15:0] cyc_q;
    logic busy_q;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // sclk falls seen within a frame
    always_ff @(posedge clk) begin
        if (sys_rst || $rose(conversion_trigger)) begin
            falls_q <= 8'h00;
        end else if ($fell(sclk) && conversion_trigger) begin
            falls_q <= falls_q + 8'h01;
        end
    end
    // cycles since the trigger rose, saturating
    always_ff @(posedge clk) begin
        if (sys_rst || $rose(conversion_trigger)) begin
            cyc_q <= 16'h0000;
        end else if (cyc_q != 16'hffff) begin
            cyc_q <= cyc_q + 16'h0001;
        end
    end
    // sclk level at the trigger rise selects the busy bit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
        end else if ($rose(conversion_trigger)) begin
            busy_q <= sclk;
        end
    end
    chk_idle_low: assert property (
        (!conversion_trigger && !chain_in)[*6] |-> !sdo)
        else $error("sdo high while trigger and chain low");
    chk_busy_rise: assert property (
        $rose(conversion_trigger) && sclk |-> ##[1:250] sdo)
        else $error("no busy bit after conversion");
    chk_busy_level: assert property (
        $fell(sclk) && conversion_trigger && falls_q == 8'h00 && busy_q
        |-> sdo)
        else $error("busy bit low at first sclk fall");
    chk_conv_wait: assert property (
        $fell(sclk) && conversion_trigger && falls_q == 8'h00
        |-> cyc_q > CONV_CYCLES)
        else $error("sclk fell before conversion end");
    chk_count_plain: assert property (
        $fell(conversion_trigger) && !$past(sys_rst) && !busy_q
        |-> falls_q == 8'h24)
        else $error("wrong fall count without busy bit");
    chk_count_busy: assert property (
        $fell(conversion_trigger) && !$past(sys_rst) && busy_q
        |-> falls_q == 8'h25)
        else $error("wrong fall count with busy bit");
    chk_trig_hold: assert property (
        conversion_trigger && falls_q < (busy_q ? 8'h25 : 8'h24)
        |=> conversion_trigger)
        else $error("trigger dropped before readout end");
    chk_shift_stable: assert property (
        conversion_trigger && sclk && $past(sclk) && falls_q != 8'h00
        |-> $stable(sdo))
        else $error("sdo moved while sclk high");
    // main scenarios
    cover property ($fell(conversion_trigger) && busy_q);
    cover property ($fell(conversion_trigger) && !busy_q);
    cover property ($fell(sclk) && falls_q == 8'h24);
endmodule
`default_nettype wire
